// ---- rtl/flash_protect_ecc_regs.sv ----
// serial command slave for sector locks, training pattern and correction register
`default_nettype none
module flash_protect_ecc_regs #(
  parameter int SECTORS = 64,
  parameter int SECTOR_SHIFT = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // serial pins from the host
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe_n,
  // read path: latency cycles of a double-rate read
  input wire logic dummy_phase,
  // correction engine events
  input wire logic corr_event,
  // array program/erase request
  input wire logic pe_req,
  input wire logic [31:0] pe_addr,
  input wire logic pe_incremental,
  input wire logic persistent_sector_lock,
  output logic pe_done,
  output logic pe_allowed,
  // state shown to the core
  output logic correction_disable,
  output logic [7:0] live_pattern,
  output logic quad_enable
);
  import flash_prot_pkg::*;

  // ==========================================================================
  // elaboration check: sector index slicing needs a power-of-two count
  if (SECTORS < 2 || (SECTORS & (SECTORS - 1)) != 0 ||
      SECTOR_SHIFT < 1 || SECTOR_SHIFT + $clog2(SECTORS) > 32) begin : g_bad_params
    $error("flash_protect_ecc_regs: unsupported SECTORS or SECTOR_SHIFT");
  end

  localparam int IDXW = $clog2(SECTORS);

  // block protect coverage
  // block protect decode: value n>0 protects top 2^(n-1) sectors, clipped to all
  function automatic logic bp_covers(input logic [3:0] bp, input logic [IDXW-1:0] idx);
    int span;
    span = 0;
    if (bp != 4'h0) begin
      span = (bp > 4'd12) ? SECTORS : (1 << (bp - 4'd1));
    end
    if (span >= SECTORS) begin
      return (bp != 4'h0);
    end
    return (int'(idx) >= SECTORS - span) && (bp != 4'h0);
  endfunction

  // sector index from a byte address
  function automatic logic [IDXW-1:0] sector_of(input logic [31:0] a);
    logic [31:0] s;
    s = a >> SECTOR_SHIFT;
    return s[IDXW-1:0];
  endfunction

  // ==========================================================================
  // pin synchronisers
  logic [1:0] sck_meta_q;
  logic [1:0] cs_meta_q;
  logic [1:0] si_meta_q;
  logic [1:0] wp_meta_q;
  logic sck_prev; // last synchronised clock level
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sck_meta_q <= 2'h0;
      cs_meta_q <= 2'h3;
      si_meta_q <= 2'h0;
      wp_meta_q <= 2'h3;
      sck_prev <= 1'b0;
    end else begin
      sck_meta_q <= {sck_meta_q[0], sck};
      cs_meta_q <= {cs_meta_q[0], cs_n};
      si_meta_q <= {si_meta_q[0], si};
      wp_meta_q <= {wp_meta_q[0], wp_n};
      sck_prev <= sck_meta_q[1];
    end
  end

  wire sck_s = sck_meta_q[1];
  wire cs_active = ~cs_meta_q[1];
  wire si_s = si_meta_q[1];
  wire wp_low = ~wp_meta_q[1];
  wire sck_rise = cs_active & sck_s & ~sck_prev;
  wire sck_fall = cs_active & ~sck_s & sck_prev;

  // ==========================================================================
  // registers
  logic dyn_lock [SECTORS]; // per-sector dynamic lock, 1 = open
  // nonvolatile copy ships as 00h and survives sys_rst
  logic [7:0] training_pattern_nonvolatile = NV_PATTERN_RESET;
  logic [7:0] training_pattern_live;
  logic live_reload; // pending copy of nonvolatile into live after reset
  logic [7:0] corr_reg;
  logic [7:0] status_reg;

  // ==========================================================================
  // serial engine state
  ser_state_t state;
  logic [2:0] bit_cnt; // bits of the current byte
  logic [6:0] in_sh; // bits collected so far
  logic [7:0] opcode;
  logic [31:0] addr; // collected address
  logic [2:0] addr_left; // address bytes still to come
  logic [7:0] out_sh; // rotating read byte
  logic [7:0] train_sh; // rotating training pattern

  wire byte_done = sck_rise & (bit_cnt == 3'h7);
  wire [7:0] rx_byte = {in_sh, si_s};
  wire [31:0] next_addr = {addr[23:0], rx_byte};
  wire [IDXW-1:0] cmd_sector = sector_of(next_addr);
  wire write_enable_latch = status_reg[ST_WEL_BIT];

  // opcode classes
  // lock read opcodes
  wire op_rd_lock = (rx_byte == OP_RD_LOCK3) | (rx_byte == OP_RD_LOCK4);
  wire op_wr_lock = (rx_byte == OP_WR_LOCK3) | (rx_byte == OP_WR_LOCK4);
  wire op_is_4b = (rx_byte == OP_RD_LOCK4) | (rx_byte == OP_WR_LOCK4);
  wire op_write_in = (rx_byte == OP_PROG_NV_PATTERN) | (rx_byte == OP_WR_LIVE_PATTERN) |
                     (rx_byte == OP_WR_CORR) | (rx_byte == OP_WRITE_STATUS);
  wire op_read_out = (rx_byte == OP_RD_PATTERN) | (rx_byte == OP_RD_CORR) |
                     (rx_byte == OP_READ_STATUS);

  // read data for simple register reads
  wire [7:0] simple_read = (rx_byte == OP_RD_PATTERN) ? training_pattern_live :
                           (rx_byte == OP_RD_CORR) ? corr_reg : status_reg;

  // write strobes, taken on the first data byte; clear and write enable on the opcode byte
  wire data_byte = byte_done & (state == S_IN);
  wire cmd_byte = byte_done & (state == S_CMD);
  // status write gate: pin low with disable set blocks the write
  wire status_locked = status_reg[ST_STATUS_WRITE_DISABLE_BIT] & wp_low;
  wire wr_status = data_byte & write_enable_latch & (opcode == OP_WRITE_STATUS) & ~status_locked;
  wire wr_lock = data_byte & write_enable_latch & ((opcode == OP_WR_LOCK3) | (opcode == OP_WR_LOCK4));
  wire wr_nv = data_byte & write_enable_latch & (opcode == OP_PROG_NV_PATTERN);
  wire wr_live = data_byte & write_enable_latch & (opcode == OP_WR_LIVE_PATTERN);
  wire wr_corr = data_byte & write_enable_latch & (opcode == OP_WR_CORR);
  wire clr_corr = cmd_byte & (rx_byte == OP_CLR_CORR);
  wire set_wel = cmd_byte & (rx_byte == OP_WRITE_ENABLE);
  wire any_write = wr_status | wr_lock | wr_nv | wr_live | wr_corr;

  // ==========================================================================
  // program/erase decision
  wire [IDXW-1:0] pe_sector = sector_of(pe_addr);
  wire bp_hit = bp_covers(status_reg[ST_BP_LSB +: 4], pe_sector);
  wire lock_hit = ~persistent_sector_lock | ~dyn_lock[pe_sector];
  wire ipa_block = pe_incremental & ~corr_reg[CORR_DIS_BIT];
  wire pe_ok = write_enable_latch & ~bp_hit & ~lock_hit & ~ipa_block;
  wire pe_consume = pe_req & write_enable_latch & ~any_write;

  // ==========================================================================
  // serial engine: bit and byte sequencing
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= S_CMD;
      bit_cnt <= 3'h0;
      in_sh <= 7'h00;
      opcode <= 8'h00;
      addr <= 32'h0;
      addr_left <= 3'h0;
    end else if (!cs_active) begin
      // deselect ends any command
      state <= S_CMD;
      bit_cnt <= 3'h0;
      addr <= 32'h0;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      in_sh <= rx_byte[6:0];
      if (bit_cnt == 3'h7) begin
        case (state)
          // opcode byte
          S_CMD: begin
            opcode <= rx_byte;
            if (op_rd_lock || op_wr_lock) begin
              state <= S_ADDR;
              addr_left <= op_is_4b ? ADDR_BYTES4 : ADDR_BYTES3;
            end else if (op_write_in) begin
              state <= S_IN;
            end else if (op_read_out) begin
              state <= S_OUT;
            end else begin
              state <= S_SKIP;
            end
          end
          // address bytes
          S_ADDR: begin
            addr <= next_addr;
            addr_left <= addr_left - 3'h1;
            if (addr_left == 3'h1) begin
              state <= (opcode == OP_RD_LOCK3 || opcode == OP_RD_LOCK4) ? S_OUT : S_IN;
            end
          end
          // one data byte, then the rest is ignored
          S_IN: state <= S_SKIP;
          S_OUT: state <= S_OUT;
          S_SKIP: state <= S_SKIP;
          default: state <= S_SKIP;
        endcase
      end
    end
  end

  // ==========================================================================
  // output shifter: read byte repeats while clocked, pattern during dummies
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      out_sh <= 8'h00;
      train_sh <= 8'h00;
      so <= 1'b0;
      so_oe_n <= 1'b1;
    end else begin
      if (byte_done && state == S_CMD && op_read_out) begin
        out_sh <= simple_read;
      end else if (byte_done && state == S_ADDR && addr_left == 3'h1) begin
        // lock byte of the addressed sector
        out_sh <= dyn_lock[cmd_sector] ? LOCK_BYTE_OPEN : LOCK_BYTE_LOCKED;
      end else if (sck_fall && state == S_OUT && !dummy_phase) begin
        out_sh <= {out_sh[6:0], out_sh[7]};
      end
      // live pattern on latency cycles
      // training pattern rotates on falling edges during latency cycles
      if (!dummy_phase || !cs_active) begin
        train_sh <= training_pattern_live;
      end else if (sck_fall) begin
        train_sh <= {train_sh[6:0], train_sh[7]};
      end
      if (sck_fall) begin
        so <= dummy_phase ? train_sh[7] : out_sh[7];
      end
      so_oe_n <= ~(cs_active & (dummy_phase | state == S_OUT));
    end
  end

  // ==========================================================================
  // dynamic sector locks, all open after reset
  // lock bytes reset open
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < SECTORS; i++) begin
        dyn_lock[i] <= 1'b1;
      end
    end else if (wr_lock) begin
      // data 00h locks, other values open
      dyn_lock[sector_of(addr)] <= (rx_byte != LOCK_BYTE_LOCKED);
    end
  end

  // ==========================================================================
  // training pattern registers
  // nonvolatile copy has no reset: it keeps its value across sys_rst
  always_ff @(posedge mclk) begin
    if (wr_nv) begin
      training_pattern_nonvolatile <= rx_byte;
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      training_pattern_live <= LIVE_PATTERN_RESET;
      live_reload <= 1'b1;
    end else begin
      live_reload <= 1'b0;
      // reload after reset, then host writes any time
      if (live_reload) begin
        training_pattern_live <= training_pattern_nonvolatile;
      end else if (wr_live) begin
        training_pattern_live <= rx_byte;
      end
    end
  end

  // ==========================================================================
  // correction register
  logic [3:0] corr_cnt;
  assign corr_cnt = corr_reg[CORR_CNT_LSB +: 4];
  wire corr_hit = corr_event & ~corr_reg[CORR_DIS_BIT];
  wire ipa_hit = pe_req & pe_incremental & ~corr_reg[CORR_DIS_BIT];
  wire [3:0] base_cnt = clr_corr ? 4'h0 : corr_cnt;
  wire [3:0] next_cnt = (corr_hit && base_cnt != CORR_CNT_MAX) ? base_cnt + 4'h1 : base_cnt;
  wire next_evt = corr_hit | (corr_reg[CORR_EVT_BIT] & ~clr_corr);
  wire next_ipa = ipa_hit | (corr_reg[CORR_IPA_BIT] & ~clr_corr);
  wire next_dis = wr_corr ? rx_byte[CORR_DIS_BIT] : corr_reg[CORR_DIS_BIT];
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      corr_reg <= CORR_RESET;
    end else begin
      // event wins over a same-cycle clear
      corr_reg <= {1'b0, next_ipa, next_cnt, next_evt, next_dis};
    end
  end

  // ==========================================================================
  // status register and write enable latch
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      status_reg <= STATUS_RESET;
    end else begin
      if (wr_status) begin
        status_reg <= (rx_byte & ST_WRITE_MASK) | (status_reg & ~ST_WRITE_MASK);
      end
      // latch set by enable, spent by any accepted write or array request
      if (set_wel) begin
        status_reg[ST_WEL_BIT] <= 1'b1;
      end else if ((data_byte && opcode != OP_WRITE_STATUS) || wr_status || pe_consume) begin
        status_reg[ST_WEL_BIT] <= 1'b0;
      end else if (data_byte && status_locked) begin
        status_reg[ST_WEL_BIT] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // program/erase answer and core-facing copies
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pe_done <= 1'b0;
      pe_allowed <= 1'b0;
      correction_disable <= 1'b0;
      live_pattern <= LIVE_PATTERN_RESET;
      quad_enable <= 1'b0;
    end else begin
      pe_done <= pe_req;
      pe_allowed <= pe_req & pe_ok & ~any_write;
      correction_disable <= corr_reg[CORR_DIS_BIT];
      live_pattern <= training_pattern_live;
      quad_enable <= status_reg[ST_QE_BIT];
    end
  end
endmodule
`default_nettype wire

// ---- inc/flash_prot_pkg.sv ----
// constants for the flash protection, training pattern and correction register block
// ==========================================================================
// How it works
// - FAh or E0h returns addressed sector lock byte
// - FBh or E1h writes addressed sector lock bit
// - lock byte 00h locked, FFh open, resets FFh
// - 41h read, 43h program, 4Ah write pattern
// - two 8-bit pattern registers, nonvolatile ships 00h
// - live pattern writable, reloaded from nonvolatile on reset
// - dummy cycles drive live pattern onto output
// - B3h read, B5h write, B6h clear correction register
// - bit0 disables correction, default 0 active
// - bit1 read-only correction event flag, default 0
// - bits 5:2 count corrections, saturate at 15
// - incremental program ignored under correction, bit6 records
// - protect pin guards block, disable, quad bits
// - status writes blocked only disable=1 and pin low
// - writes need write enable latch set first
// - block protect leaves other sectors lockable
// - sector protected if either scheme protects it
// - four block-protect bits protect top portion
// - persistent or dynamic lock zero refuses program
`default_nettype none
package flash_prot_pkg;
  // ==========================================================================
  // opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_RD_LOCK3 = 8'hFA;
  localparam logic [7:0] OP_RD_LOCK4 = 8'hE0;
  localparam logic [7:0] OP_WR_LOCK3 = 8'hFB;
  localparam logic [7:0] OP_WR_LOCK4 = 8'hE1;
  localparam logic [7:0] OP_RD_PATTERN = 8'h41;
  localparam logic [7:0] OP_PROG_NV_PATTERN = 8'h43;
  localparam logic [7:0] OP_WR_LIVE_PATTERN = 8'h4A;
  localparam logic [7:0] OP_RD_CORR = 8'hB3;
  localparam logic [7:0] OP_WR_CORR = 8'hB5;
  localparam logic [7:0] OP_CLR_CORR = 8'hB6;
  // ==========================================================================
  // lock byte values
  localparam logic [7:0] LOCK_BYTE_LOCKED = 8'h00;
  localparam logic [7:0] LOCK_BYTE_OPEN = 8'hFF;
  // ==========================================================================
  // reset values
  localparam logic [7:0] NV_PATTERN_RESET = 8'h00;
  localparam logic [7:0] LIVE_PATTERN_RESET = 8'h00;
  localparam logic [7:0] CORR_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // ==========================================================================
  // correction register fields
  localparam int CORR_DIS_BIT = 0;
  localparam int CORR_EVT_BIT = 1;
  localparam int CORR_CNT_LSB = 2;
  localparam int CORR_IPA_BIT = 6;
  localparam logic [3:0] CORR_CNT_MAX = 4'hF;
  // ==========================================================================
  // status register fields
  localparam int ST_WEL_BIT = 1;
  localparam int ST_BP_LSB = 2;
  localparam int ST_QE_BIT = 6;
  localparam int ST_STATUS_WRITE_DISABLE_BIT = 7;
  localparam logic [7:0] ST_WRITE_MASK = 8'hFC;
  // ==========================================================================
  // address byte counts
  localparam logic [2:0] ADDR_BYTES3 = 3'h3;
  localparam logic [2:0] ADDR_BYTES4 = 3'h4;
  // ==========================================================================
  // serial engine states
  typedef enum logic [2:0] {
    S_CMD = 3'b000,
    S_ADDR = 3'b001,
    S_IN = 3'b010,
    S_OUT = 3'b011,
    S_SKIP = 3'b100
  } ser_state_t;
endpackage
`default_nettype wire

// ---- dv/flash_prot_chk.sv ----
// pin-level assertions for the flash protection register block
`default_nettype none
module flash_prot_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // serial side
  input wire logic cs_n,
  input wire logic so_oe_n,
  input wire logic dummy_phase,
  // program/erase side
  input wire logic pe_req,
  input wire logic pe_incremental,
  input wire logic persistent_sector_lock,
  input wire logic pe_done,
  input wire logic pe_allowed,
  // state shown to the core
  input wire logic correction_disable,
  input wire logic [7:0] live_pattern,
  input wire logic quad_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // one clock domain, reset masks every check
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // program/erase answers
  chk_done_follows:
    assert property (pe_done == $past(pe_req))
    else $error("pe_done not one cycle after pe_req");
  chk_persist_refuse:
    assert property (pe_req && !persistent_sector_lock |=> pe_done && !pe_allowed)
    else $error("persistent lock did not refuse");
  chk_incr_refuse:
    assert property (pe_req && pe_incremental && !correction_disable |=> !pe_allowed)
    else $error("incremental program allowed under correction");
  // ==========================================================================
  // state only moves inside a frame
  chk_disable_quiet:
    assert property (cs_n && $past(cs_n, 5) |-> $stable(correction_disable))
    else $error("correction_disable moved while deselected");
  chk_pattern_quiet:
    assert property (cs_n && $past(cs_n, 5) && !$past(sys_rst, 3) |-> $stable(live_pattern))
    else $error("live_pattern moved while deselected");
  chk_quad_quiet:
    assert property (cs_n && $past(cs_n, 5) |-> $stable(quad_enable))
    else $error("quad_enable moved while deselected");
  // ==========================================================================
  // output driver enable
  chk_dummy_drive:
    assert property (dummy_phase && $past(dummy_phase) && !cs_n && !$past(cs_n, 4)
      |-> !so_oe_n)
    else $error("so not driven in training cycles");
  chk_idle_release:
    assert property (cs_n && $past(cs_n, 5) && !$past(dummy_phase) |-> so_oe_n)
    else $error("so driven while deselected");
endmodule
bind flash_protect_ecc_regs flash_prot_chk chk_u (
  .mclk(mclk), .sys_rst(sys_rst), .cs_n(cs_n), .so_oe_n(so_oe_n),
  .dummy_phase(dummy_phase), .pe_req(pe_req), .pe_incremental(pe_incremental),
  .persistent_sector_lock(persistent_sector_lock), .pe_done(pe_done),
  .pe_allowed(pe_allowed), .correction_disable(correction_disable),
  .live_pattern(live_pattern), .quad_enable(quad_enable)
);
`default_nettype wire

// ---- dv/spi_host_model.sv ----
// serial host model that clocks command frames into the block
`default_nettype none
module spi_host_model (
  // pacing clock
  input wire logic mclk,
  // serial pins
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 1ps;
  // deselected, clock parked low between frames
  initial begin
    sck = 1'h0;
    cs_n = 1'h1;
    si = 1'h0;
  end
  // half of the 80 ns serial period
  task automatic half();
    repeat (8) @(negedge mclk);
  endtask
  task automatic frame(input logic [47:0] tx, input int n, input int rd,
                       output logic [7:0] rx);
    rx = 8'h00;
    cs_n = 1'h0;
    for (int i = 0; i < 8 * (n + rd); i++) begin
      // read slots toggle si so no stale copy lingers
      si = (i < 8 * n) ? tx[47 - i] : ~si;
      half();
      sck = 1'h1;
      if (i >= 8 * n) rx = {rx[6:0], so};
      half();
      sck = 1'h0;
    end
    half();
    cs_n = 1'h1;
    si = ~si;
    half();
  endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the flash protection register block
`default_nettype none
module tb;
  import flash_prot_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // signals
  logic mclk, sys_rst, sck, cs_n, si, wp_n, so, so_oe_n, dummy_phase, corr_event;
  logic pe_req, pe_incremental, persistent_sector_lock, pe_done, pe_allowed;
  logic correction_disable, quad_enable;
  logic [31:0] pe_addr;
  logic [7:0] live_pattern, rx;
  int n_mismatch, n_compared;
  // ==========================================================================
  // block and host
  flash_protect_ecc_regs dut_u (
    .mclk(mclk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .so(so), .so_oe_n(so_oe_n), .dummy_phase(dummy_phase), .corr_event(corr_event),
    .pe_req(pe_req), .pe_addr(pe_addr), .pe_incremental(pe_incremental),
    .persistent_sector_lock(persistent_sector_lock), .pe_done(pe_done),
    .pe_allowed(pe_allowed), .correction_disable(correction_disable),
    .live_pattern(live_pattern), .quad_enable(quad_enable)
  );
  spi_host_model host_u (.mclk(mclk), .sck(sck), .cs_n(cs_n), .si(si), .so(so));
  // 200 MHz clock
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  // ==========================================================================
  // helpers
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic f(input logic [47:0] tx, input int n, input int rd);
    host_u.frame(tx, n, rd, rx);
  endtask
  task automatic we();
    f({OP_WRITE_ENABLE, 40'h0}, 1, 0);
  endtask
  // one program/erase request, answer judged a cycle later
  task automatic pe(input logic [31:0] a, input logic inc, input logic pl, input logic ok);
    @(negedge mclk);
    pe_addr = a;
    pe_incremental = inc;
    persistent_sector_lock = pl;
    pe_req = 1'h1;
    @(negedge mclk);
    pe_req = 1'h0;
    check("pe_done", 8'h01, 8'(pe_done));
    check("pe_allowed", 8'(ok), 8'(pe_allowed));
  endtask
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    check("so_oe_n", 8'h01, 8'(so_oe_n));
    check("disable", 8'h00, 8'(correction_disable));
    check("live", NV_PATTERN_RESET, live_pattern);
    f({OP_RD_LOCK3, 24'h3F0000, 16'h0}, 4, 1);
    check("lock reset", LOCK_BYTE_OPEN, rx);
    f({OP_RD_CORR, 40'h0}, 1, 1);
    check("corr reset", CORR_RESET, rx);
    $display("test reset done");
  endtask
  task automatic t_locks();
    // sector locks used alone, block protect clear
    f({OP_WR_LOCK3, 24'h050000, 16'h0}, 5, 0);
    f({OP_RD_LOCK3, 24'h050000, 16'h0}, 4, 1);
    check("lock no latch", LOCK_BYTE_OPEN, rx);
    we();
    f({OP_WR_LOCK3, 24'h050000, 16'h0}, 5, 0);
    f({OP_RD_LOCK4, 32'h00050000, 8'h0}, 5, 1);
    check("lock set", LOCK_BYTE_LOCKED, rx);
    we();
    pe(32'h00051234, 1'h0, 1'h1, 1'h0);
    we();
    pe(32'h00060000, 1'h0, 1'h1, 1'h1);
    we();
    pe(32'h00060000, 1'h0, 1'h0, 1'h0);
    pe(32'h00060000, 1'h0, 1'h1, 1'h0);
    we();
    f({OP_WR_LOCK4, 32'h00050000, 8'hFF}, 6, 0);
    f({OP_RD_LOCK3, 24'h050000, 16'h0}, 4, 1);
    check("lock open", LOCK_BYTE_OPEN, rx);
    $display("test locks done");
  endtask
  task automatic t_pattern();
    logic [15:0] dbl;
    logic hit;
    we();
    f({OP_WR_LIVE_PATTERN, 8'hA5, 32'h0}, 2, 0);
    check("live write", 8'hA5, live_pattern);
    fork
      f({OP_RD_PATTERN, 40'h0}, 1, 1);
      begin
        repeat (100) @(negedge mclk);
        dummy_phase = 1'h1;
        repeat (4) @(negedge mclk);
        check("oe training", 8'h00, 8'(so_oe_n));
        dummy_phase = 1'h0;
      end
    join
    check("live read", 8'hA5, rx);
    we();
    f({OP_PROG_NV_PATTERN, 8'h3C, 32'h0}, 2, 0);
    check("live kept", 8'hA5, live_pattern);
    sys_rst = 1'h1;
    repeat (3) @(negedge mclk);
    sys_rst = 1'h0;
    repeat (8) @(negedge mclk);
    check("live reload", 8'h3C, live_pattern);
    // latency bits carry the live pattern, in any phase
    dummy_phase = 1'h1;
    f({8'h00, 40'h0}, 1, 1);
    dummy_phase = 1'h0;
    dbl = {rx, rx};
    hit = 1'h0;
    for (int k = 0; k < 8; k++) begin
      if (dbl[15 - k -: 8] == 8'h3C) begin
        hit = 1'h1;
      end
    end
    check("training bits", 8'h01, 8'(hit));
    $display("test pattern done");
  endtask
  task automatic t_corr();
    repeat (17) begin
      corr_event = 1'h1;
      @(negedge mclk);
      corr_event = 1'h0;
      @(negedge mclk);
    end
    f({OP_RD_CORR, 40'h0}, 1, 1);
    check("corr saturate", 8'h3E, rx);
    we();
    f({OP_WR_CORR, 8'h01, 32'h0}, 2, 0);
    check("disable set", 8'h01, 8'(correction_disable));
    f({OP_CLR_CORR, 40'h0}, 1, 0);
    f({OP_RD_CORR, 40'h0}, 1, 1);
    check("corr cleared", 8'h01, rx);
    we();
    pe(32'h00000000, 1'h1, 1'h1, 1'h1);
    we();
    f({OP_WR_CORR, 8'h00, 32'h0}, 2, 0);
    we();
    pe(32'h00000000, 1'h1, 1'h1, 1'h0);
    f({OP_RD_CORR, 40'h0}, 1, 1);
    check("corr attempt", 8'h40, rx);
    $display("test correction done");
  endtask
  task automatic t_status();
    we();
    f({OP_WRITE_STATUS, 8'hC4, 32'h0}, 2, 0);
    check("quad set", 8'h01, 8'(quad_enable));
    f({OP_READ_STATUS, 40'h0}, 1, 1);
    check("status", 8'hC4, rx);
    we();
    pe(32'h003F0000, 1'h0, 1'h1, 1'h0);
    we();
    pe(32'h00000000, 1'h0, 1'h1, 1'h1);
    we();
    f({OP_WR_LOCK3, 24'h000000, 16'h0}, 5, 0);
    we();
    pe(32'h00000000, 1'h0, 1'h1, 1'h0);
    wp_n = 1'h0;
    we();
    f({OP_WRITE_STATUS, 8'h00, 32'h0}, 2, 0);
    check("quad guarded", 8'h01, 8'(quad_enable));
    wp_n = 1'h1;
    we();
    f({OP_WRITE_STATUS, 8'h00, 32'h0}, 2, 0);
    check("quad cleared", 8'h00, 8'(quad_enable));
    $display("test status done");
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    sys_rst = 1'h1;
    {wp_n, persistent_sector_lock} = 2'h3;
    {dummy_phase, corr_event, pe_req, pe_incremental} = 4'h0;
    pe_addr = 32'h0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (3) @(negedge mclk);
    sys_rst = 1'h0;
    repeat (8) @(negedge mclk);
    t_reset();
    t_locks();
    t_pattern();
    t_corr();
    t_status();
    conclude();
  end
  // watchdog against a hung handshake
  initial begin
    #400000;
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
